/* taf_pkg.sv */
/*
 * Package for the transfer activation and information fetch block:
 * register offsets, field positions, memory layout of the transfer
 * information, fetch states and the carrier structs.
 * Assumes a 32-bit classic Wishbone register bus and a 32-bit memory port.
 */
`default_nettype none
package taf_pkg;
	localparam int          NUM_SRC        = 30;
	// register byte offsets
	localparam logic [7:0]  OFS_CTRL       = 8'h00;
	localparam logic [7:0]  OFS_BASE       = 8'h04;
	localparam logic [7:0]  OFS_ENABLE     = 8'h08;
	localparam logic [7:0]  OFS_STATUS     = 8'h0c;
	// control/status fields
	localparam int          BIT_NMI        = 10;
	localparam int          BIT_AERR       = 9;
	localparam int          BIT_SWEN       = 8;
	localparam logic [15:0] CTRL_RESET     = 16'h0000;
	localparam logic [29:0] ENABLE_RESET   = 30'h00000000;
	// vector table
	localparam logic [31:0] VEC_BASE       = 32'h00000400;
	// mode word fields
	localparam int          MW_MODE_LO     = 0;
	localparam int          MW_NMI_CONT    = 2;
	localparam int          MW_CLR_ENABLE  = 3;
	localparam logic [1:0]  MODE_NORMAL    = 2'h0;
	localparam logic [1:0]  MODE_REPEAT    = 2'h1;
	localparam logic [1:0]  MODE_BLOCK     = 2'h2;
	// information block layout, bytes from the start address
	localparam logic [31:0] INFO_MODE      = 32'h00000000;
	localparam logic [31:0] INFO_CNTA      = 32'h00000002;
	localparam logic [31:0] INFO_INIT      = 32'h00000004;
	localparam logic [31:0] INFO_CNTB      = 32'h00000006;
	localparam logic [31:0] INFO_SRC       = 32'h00000008;
	localparam logic [31:0] INFO_DST       = 32'h0000000c;

	typedef enum logic [12:0] {
		ST_IDLE  = 13'h0001,
		ST_VEC   = 13'h0002,
		ST_MODE  = 13'h0004,
		ST_CNTA  = 13'h0008,
		ST_INIT  = 13'h0010,
		ST_CNTB  = 13'h0020,
		ST_SRC   = 13'h0040,
		ST_DST   = 13'h0080,
		ST_XFER  = 13'h0100,
		ST_WCNT  = 13'h0200,
		ST_WSRC  = 13'h0400,
		ST_WDST  = 13'h0800,
		ST_DONE  = 13'h1000
	} taf_state_t;

	typedef struct packed {
		logic        req;
		logic        we;
		logic        long_acc;
		logic [31:0] addr;
		logic [31:0] wdata;
	} taf_mem_req_t;

	typedef struct packed {
		logic [15:0] mode_word;
		logic [15:0] count_a_word;
		logic [15:0] count_b_word;
		logic [31:0] initial_addr_word;
		logic [31:0] source_addr_word;
		logic [31:0] dest_addr_word;
	} taf_info_t;

	typedef struct packed {
		logic [15:0] count_a_word;
		logic [31:0] source_addr_word;
		logic [31:0] dest_addr_word;
		logic        last;
	} taf_update_t;
endpackage : taf_pkg
`default_nettype wire

/* taf_fetch.sv */
/*
 * Activation, vector lookup and information fetch of the transfer
 * controller, with its Wishbone register slave and write-back.
 * Assumes an external datapath that moves the data once the information
 * has been handed over, and a memory port that answers each request
 * with one ack pulse.
 */
`default_nettype none
// Functional notes
// - software vector address is 0x0400 plus the eight-bit vector field
// - vector field is writable only while software enable reads zero
// - nmi and address-error flags clear only by 0 write after reading 1
// - software enable: 1 always writable, 0 only after reading 1
// - info base register is 16-bit read/write, upper address half
// - info base register has no reset value
// - start on interrupt request or on software control register write
// - request goes to controller if its enable is set, else to cpu
// - at transfer end clear source flag or its enable bit
// - interrupt activation ignores cpu mask and programmed priorities
// - simultaneous requests are served in fixed default priority
// - hardware sources map to 2-byte entries from 0x400 to 0x43a
// - start address is info base upper half plus vector entry lower half
// - normal mode: mode, count a, 4 spare bytes, source, destination
// - repeat mode: mode, count a, initial, source, destination
// - block mode: mode, count a, 2 spare bytes, count b, source, destination
// - each source owns one 2-byte vector entry holding start low half
// - fetch vector first, then information from that start address
// - nmi flag blocks new starts; continue-mode transfer still finishes
// - address-error flag blocks every start
// - writing 1 to software enable triggers a software transfer
// - updated information is written back after each transfer
module taf_fetch (
	input  wire logic                    sys_clk,
	input  wire logic                    resetn,
	input  wire logic                    wb_cyc_i,
	input  wire logic                    wb_stb_i,
	input  wire logic                    wb_we_i,
	input  wire logic [7:0]              wb_adr_i,
	input  wire logic [3:0]              wb_sel_i,
	input  wire logic [31:0]             wb_dat_i,
	output logic      [31:0]             wb_dat_o,
	output logic                         wb_ack_o,
	input  wire logic [taf_pkg::NUM_SRC-1:0] irq_req,
	output logic      [taf_pkg::NUM_SRC-1:0] cpu_irq,
	output logic      [taf_pkg::NUM_SRC-1:0] src_flag_clear,
	input  wire logic                    nmi_event,
	output taf_pkg::taf_mem_req_t        mem_o,
	input  wire logic                    mem_ack,
	input  wire logic                    mem_err,
	input  wire logic [31:0]             mem_rdata,
	output logic                         xfer_valid,
	output taf_pkg::taf_info_t           xfer_info,
	input  wire logic                    xfer_done,
	input  wire taf_pkg::taf_update_t    xfer_update
);
	import taf_pkg::*;

	taf_state_t          state;
	logic [15:0]         ctrl;
	logic [15:0]         info_base_reg;
	logic [NUM_SRC-1:0]  per_source_enable_bits;
	logic                nmi_armed;
	logic                aerr_armed;
	logic                swen_armed;
	logic                sw_job;
	logic [4:0]          job_src;
	logic [31:0]         start_addr;
	taf_update_t         upd;
	logic                bus_go;
	logic                wr_ctrl;
	logic                rd_ctrl;
	logic [NUM_SRC-1:0]  pending;
	logic                hw_any;
	logic [4:0]          hw_idx;
	logic                start_ok;
	logic                nmi_stop;
	logic                fetch_ack;
	logic [31:0]         next_addr;

	assign bus_go  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr_ctrl = bus_go & wb_we_i & (wb_adr_i == OFS_CTRL);
	assign rd_ctrl = bus_go & ~wb_we_i & (wb_adr_i == OFS_CTRL);

	// routing needs no mask or priority level from the interrupt controller
	// a source whose flag is being cleared this cycle must not restart the engine
	assign pending = irq_req & per_source_enable_bits & ~src_flag_clear;
	assign cpu_irq = irq_req & ~per_source_enable_bits;

	function automatic logic [5:0] hw_idx_x2(input logic [4:0] idx);
		hw_idx_x2 = {idx, 1'b0};
	endfunction : hw_idx_x2

	always_comb begin
		hw_any = 1'b0;
		hw_idx = 5'h00;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (pending[i]) begin
				hw_any = 1'b1;
				hw_idx = 5'(i);
			end
		end
	end

	assign start_ok = ~ctrl[BIT_NMI] & ~ctrl[BIT_AERR];
	assign nmi_stop = ctrl[BIT_NMI] & ~xfer_info.mode_word[MW_NMI_CONT];
	assign fetch_ack = mem_ack & ~mem_err;

	// register slave: one wait state, unmapped offsets read zero
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= bus_go;
			if (bus_go & ~wb_we_i) begin
				case (wb_adr_i)
					OFS_CTRL:   wb_dat_o <= {16'h0000, ctrl};
					OFS_BASE:   wb_dat_o <= {16'h0000, info_base_reg};
					OFS_ENABLE: wb_dat_o <= {2'h0, per_source_enable_bits};
					OFS_STATUS: wb_dat_o <= {18'h00000, job_src, state != ST_IDLE,
						sw_job, 7'h00};
					default:    wb_dat_o <= 32'h00000000;
				endcase
			end
		end
	end

	// info base carries no reset; byte lanes follow sel
	always_ff @(posedge sys_clk) begin
		if (bus_go & wb_we_i & (wb_adr_i == OFS_BASE)) begin
			if (wb_sel_i[0])
				info_base_reg[7:0] <= wb_dat_i[7:0];
			if (wb_sel_i[1])
				info_base_reg[15:8] <= wb_dat_i[15:8];
		end
	end

	// read-as-one memory for the write-zero clear conditions
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			nmi_armed  <= 1'b0;
			aerr_armed <= 1'b0;
			swen_armed <= 1'b0;
		end else if (rd_ctrl) begin
			nmi_armed  <= ctrl[BIT_NMI];
			aerr_armed <= ctrl[BIT_AERR];
			swen_armed <= ctrl[BIT_SWEN];
		end else if (wr_ctrl & wb_sel_i[1]) begin
			nmi_armed  <= 1'b0;
			aerr_armed <= 1'b0;
			swen_armed <= 1'b0;
		end
	end

	// control/status: hardware sets win over software clears
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			ctrl <= CTRL_RESET;
		end else begin
			// end-of-job clear first so a software set in the same cycle wins
			if (state == ST_DONE && sw_job && upd.last)
				ctrl[BIT_SWEN] <= 1'b0;
			if (wr_ctrl & wb_sel_i[0] & ~ctrl[BIT_SWEN])
				ctrl[7:0] <= wb_dat_i[7:0];
			if (wr_ctrl & wb_sel_i[1]) begin
				if (!wb_dat_i[BIT_NMI] && nmi_armed)
					ctrl[BIT_NMI] <= 1'b0;
				if (!wb_dat_i[BIT_AERR] && aerr_armed)
					ctrl[BIT_AERR] <= 1'b0;
				if (wb_dat_i[BIT_SWEN])
					ctrl[BIT_SWEN] <= 1'b1;
				else if (swen_armed)
					ctrl[BIT_SWEN] <= 1'b0;
			end
			if (nmi_event)
				ctrl[BIT_NMI] <= 1'b1;
			if ((state != ST_IDLE) && (state != ST_XFER) && mem_ack && mem_err)
				ctrl[BIT_AERR] <= 1'b1;
			if (state == ST_VEC && fetch_ack && (mem_rdata[1:0] != 2'h0))
				ctrl[BIT_AERR] <= 1'b1;
		end
	end

	// per-source enables; end-of-transfer clear when the mode word asks
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			per_source_enable_bits <= ENABLE_RESET;
		end else begin
			if (bus_go & wb_we_i & (wb_adr_i == OFS_ENABLE)) begin
				for (int b = 0; b < 4; b++) begin
					if (wb_sel_i[b]) begin
						for (int k = 0; k < 8; k++) begin
							if (b * 8 + k < NUM_SRC)
								per_source_enable_bits[b * 8 + k] <= wb_dat_i[b * 8 + k];
						end
					end
				end
			end
			if (state == ST_DONE && !sw_job && upd.last &&
				xfer_info.mode_word[MW_CLR_ENABLE])
				per_source_enable_bits[job_src] <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			src_flag_clear <= '0;
		end else begin
			src_flag_clear <= '0;
			if (state == ST_DONE && !sw_job && upd.last &&
				!xfer_info.mode_word[MW_CLR_ENABLE])
				src_flag_clear[job_src] <= 1'b1;
		end
	end

	// memory request for the current state
	always_comb begin
		next_addr = start_addr;
		case (state)
			ST_VEC:  next_addr = sw_job ? VEC_BASE + {24'h000000, ctrl[7:0]}
				: VEC_BASE + {26'h0000000, hw_idx_x2(job_src)};
			ST_MODE: next_addr = start_addr + INFO_MODE;
			ST_CNTA: next_addr = start_addr + INFO_CNTA;
			ST_INIT: next_addr = start_addr + INFO_INIT;
			ST_CNTB: next_addr = start_addr + INFO_CNTB;
			ST_SRC:  next_addr = start_addr + INFO_SRC;
			ST_DST:  next_addr = start_addr + INFO_DST;
			ST_WCNT: next_addr = start_addr + INFO_CNTA;
			ST_WSRC: next_addr = start_addr + INFO_SRC;
			ST_WDST: next_addr = start_addr + INFO_DST;
			default: next_addr = start_addr;
		endcase
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			mem_o <= '0;
		end else begin
			mem_o.req      <= 1'b0;
			mem_o.addr     <= next_addr;
			mem_o.we       <= (state == ST_WCNT) | (state == ST_WSRC) | (state == ST_WDST);
			mem_o.long_acc <= (state == ST_INIT) | (state == ST_SRC) | (state == ST_DST) |
				(state == ST_WSRC) | (state == ST_WDST);
			case (state)
				ST_WCNT: mem_o.wdata <= {16'h0000, upd.count_a_word};
				ST_WSRC: mem_o.wdata <= upd.source_addr_word;
				ST_WDST: mem_o.wdata <= upd.dest_addr_word;
				default: mem_o.wdata <= 32'h00000000;
			endcase
			if ((state != ST_IDLE) && (state != ST_XFER) && (state != ST_DONE) &&
				!mem_ack && !mem_o.req)
				mem_o.req <= 1'b1;
			else if (mem_o.req && !mem_ack)
				mem_o.req <= 1'b1;
		end
	end

	// activation and fetch sequence
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state      <= ST_IDLE;
			sw_job     <= 1'b0;
			job_src    <= 5'h00;
			start_addr <= 32'h00000000;
			xfer_info  <= '0;
			xfer_valid <= 1'b0;
			upd        <= '0;
		end else begin
			case (state)
				ST_IDLE: begin
					if (start_ok && hw_any) begin
						sw_job  <= 1'b0;
						job_src <= hw_idx;
						state   <= ST_VEC;
					end else if (start_ok && ctrl[BIT_SWEN]) begin
						sw_job  <= 1'b1;
						state   <= ST_VEC;
					end
				end
				ST_VEC: if (mem_ack) begin
					start_addr <= {info_base_reg, mem_rdata[15:0]};
					state <= (mem_err || mem_rdata[1:0] != 2'h0) ? ST_IDLE : ST_MODE;
				end
				ST_MODE: if (mem_ack) begin
					xfer_info.mode_word <= mem_rdata[15:0];
					state <= mem_err ? ST_IDLE : ST_CNTA;
				end
				ST_CNTA: if (mem_ack) begin
					xfer_info.count_a_word <= mem_rdata[15:0];
					if (mem_err || nmi_stop)
						state <= ST_IDLE;
					else if (xfer_info.mode_word[MW_MODE_LO +: 2] == MODE_REPEAT)
						state <= ST_INIT;
					else if (xfer_info.mode_word[MW_MODE_LO +: 2] == MODE_BLOCK)
						state <= ST_CNTB;
					else
						state <= ST_SRC;
				end
				ST_INIT: if (mem_ack) begin
					xfer_info.initial_addr_word <= mem_rdata;
					state <= mem_err ? ST_IDLE : ST_SRC;
				end
				ST_CNTB: if (mem_ack) begin
					xfer_info.count_b_word <= mem_rdata[15:0];
					state <= mem_err ? ST_IDLE : ST_SRC;
				end
				ST_SRC: if (mem_ack) begin
					xfer_info.source_addr_word <= mem_rdata;
					state <= mem_err ? ST_IDLE : ST_DST;
				end
				ST_DST: if (mem_ack) begin
					xfer_info.dest_addr_word <= mem_rdata;
					xfer_valid <= ~mem_err & ~nmi_stop;
					state <= (mem_err || nmi_stop) ? ST_IDLE : ST_XFER;
				end
				ST_XFER: if (xfer_done) begin
					xfer_valid <= 1'b0;
					upd   <= xfer_update;
					state <= ST_WCNT;
				end
				ST_WCNT: if (mem_ack)
					state <= mem_err ? ST_IDLE : ST_WSRC;
				ST_WSRC: if (mem_ack)
					state <= mem_err ? ST_IDLE : ST_WDST;
				ST_WDST: if (mem_ack)
					state <= mem_err ? ST_IDLE : ST_DONE;
				ST_DONE:
					state <= ST_IDLE;
				default:
					state <= ST_IDLE;
			endcase
		end
	end
endmodule : taf_fetch
`default_nettype wire

/* taf_chk.sv */
/* port checker for taf_fetch
 * bound onto taf_fetch, sees only its ports */
`default_nettype none
module taf_chk (
	input wire logic				sys_clk,
	input wire logic				resetn,
	input wire logic				wb_cyc_i,
	input wire logic				wb_stb_i,
	input wire logic				wb_ack_o,
	input wire logic [taf_pkg::NUM_SRC-1:0]	irq_req,
	input wire logic [taf_pkg::NUM_SRC-1:0]	cpu_irq,
	input wire logic [taf_pkg::NUM_SRC-1:0]	src_flag_clear,
	input wire taf_pkg::taf_mem_req_t		mem_o,
	input wire logic				mem_ack,
	input wire logic				mem_err,
	input wire logic				xfer_valid,
	input wire logic				xfer_done,
	input wire taf_pkg::taf_info_t		xfer_info
);
	import taf_pkg::*;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not acked");
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	chk_cpu_route: assert property ((cpu_irq & ~irq_req) == '0)
		else $error("cpu request without source");
	chk_clear_pulse: assert property (|src_flag_clear |-> $onehot(src_flag_clear) ##1 src_flag_clear == '0)
		else $error("bad flag clear pulse");
	chk_req_hold: assert property (mem_o.req && !mem_ack |=> mem_o.req && $stable(mem_o.addr) && $stable(mem_o.we))
		else $error("memory request moved before ack");
	chk_req_gap: assert property (mem_ack |=> !mem_o.req)
		else $error("no idle cycle after ack");
	chk_err_block: assert property (mem_ack && mem_err |=> !mem_o.req [*8])
		else $error("start after address error");
	chk_info_hold: assert property (xfer_valid && !xfer_done |=> xfer_valid && $stable(xfer_info))
		else $error("info changed while handed over");
	chk_wb_after: assert property (xfer_valid && xfer_done |=> !xfer_valid ##[0:4] (mem_o.req && mem_o.we))
		else $error("no write-back after transfer");
	chk_idle_busy: assert property (xfer_valid |-> !mem_o.req)
		else $error("memory access during transfer");
endmodule : taf_chk
bind taf_fetch taf_chk u_taf_chk (
	.sys_clk(sys_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o), .irq_req(irq_req), .cpu_irq(cpu_irq), .src_flag_clear(src_flag_clear),
	.mem_o(mem_o), .mem_ack(mem_ack), .mem_err(mem_err), .xfer_valid(xfer_valid),
	.xfer_done(xfer_done), .xfer_info(xfer_info));
`default_nettype wire

/* taf_mem_model.sv */
/* memory partner of taf_fetch: sparse word store on the memory port
 * assumes one request at a time, held until ack */
`default_nettype none
module taf_mem_model (
	input wire logic			sys_clk,
	input wire logic			resetn,
	input wire taf_pkg::taf_mem_req_t	mem_i,
	input wire logic			slow,
	input wire logic [31:0]		err_addr,
	output logic			mem_ack,
	output logic			mem_err,
	output logic [31:0]		mem_rdata
);
	import taf_pkg::*;
	logic [31:0]	mem [logic [31:0]];
	logic [1:0]	wait_cnt;
	// released data is inverted so a stale word never passes for a fresh one
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			mem_ack <= 1'b0;
			mem_err <= 1'b0;
			mem_rdata <= 32'h0;
			wait_cnt <= 2'h0;
		end else if (mem_ack) begin
			mem_ack <= 1'b0;
			mem_err <= 1'b0;
			mem_rdata <= ~mem_rdata;
		end else if (mem_i.req && slow && wait_cnt != 2'h2) begin
			wait_cnt <= wait_cnt + 2'h1;
		end else if (mem_i.req) begin
			wait_cnt <= 2'h0;
			mem_ack <= 1'b1;
			mem_err <= mem_i.addr == err_addr;
			if (mem_i.we && mem_i.addr != err_addr)
				mem[mem_i.addr] = mem_i.wdata;
			else if (mem.exists(mem_i.addr))
				mem_rdata <= mem[mem_i.addr];
			else
				mem_rdata <= 32'h0;
		end
	end
endmodule : taf_mem_model
`default_nettype wire

/* test_transfer_activation_fetch.sv */
/* self-checking bench for taf_fetch
 * assumes taf_mem_model as memory; the bench plays cpu, peripherals and datapath */
`default_nettype none
module test_transfer_activation_fetch;
	timeunit 1ns;
	timeprecision 1ps;
	import taf_pkg::*;
	localparam logic [15:0]	BASE = 16'h0012;
	logic			sys_clk = 1'b0, resetn = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
	logic			wb_we_i = 1'b0, nmi_event = 1'b0, xfer_done = 1'b0, slow = 1'b0;
	logic [7:0]		wb_adr_i = '0;
	logic [3:0]		wb_sel_i = '0;
	logic [31:0]		wb_dat_i = '0, err_addr = '1, wb_dat_o, mem_rdata;
	logic			wb_ack_o, mem_ack, mem_err, xfer_valid;
	logic [NUM_SRC-1:0]	irq_req = '0, cpu_irq, src_flag_clear;
	taf_mem_req_t		mem_o;
	taf_info_t		xfer_info;
	taf_update_t		xfer_update = '0;
	logic [79:0]		exp_mem [$], exp_wr [$];
	logic [31:0]		exp_rd [$], exp_start [$];
	taf_info_t		exp_info [$];
	logic [15:0]		rnd = 16'h005c;
	int			n_mismatch = 0, checks = 0, cyc = 0;

	always #5 sys_clk = ~sys_clk;

	taf_fetch u_taf_fetch (.sys_clk(sys_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_req(irq_req),
		.cpu_irq(cpu_irq), .src_flag_clear(src_flag_clear), .nmi_event(nmi_event),
		.mem_o(mem_o), .mem_ack(mem_ack), .mem_err(mem_err), .mem_rdata(mem_rdata),
		.xfer_valid(xfer_valid), .xfer_info(xfer_info), .xfer_done(xfer_done),
		.xfer_update(xfer_update));
	taf_mem_model u_taf_mem_model (.sys_clk(sys_clk), .resetn(resetn), .mem_i(mem_o),
		.slow(slow), .err_addr(err_addr), .mem_ack(mem_ack), .mem_err(mem_err),
		.mem_rdata(mem_rdata));

	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : lfsr

	task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : chk

	task automatic push(input logic we, input logic lg, input logic [31:0] a, input logic [31:0] d);
		// write-backs of one job may overtake reads of the next, so keep them apart
		if (we) exp_wr.push_back({14'h0, we, lg, a, d});
		else exp_mem.push_back({14'h0, we, lg, a, d});
	endtask : push

	task automatic wb(input logic we, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
		@(posedge sys_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_sel_i <= s;
		wb_dat_i <= d;
		do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : wb

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_rd.push_back(e);
		wb(1'b0, a, 4'hf, 32'h0);
	endtask : rd

	task automatic settle;
		while (exp_mem.size() != 0 || exp_wr.size() != 0 || exp_info.size() != 0)
			@(posedge sys_clk);
		repeat (4) @(posedge sys_clk);
	endtask : settle

	task automatic job(input logic [31:0] va, input logic [31:0] st, input logic [15:0] m);
		taf_info_t i;
		rnd = lfsr(rnd);
		slow <= rnd[0];
		i = {m, rnd, rnd ^ 16'h00ff, {rnd, ~rnd}, {rnd, rnd}, {~rnd, rnd}};
		u_taf_mem_model.mem[va] = {16'h0, st[15:0]};
		u_taf_mem_model.mem[st + INFO_MODE] = {16'h0, m};
		u_taf_mem_model.mem[st + INFO_CNTA] = {16'h0, i.count_a_word};
		u_taf_mem_model.mem[st + INFO_INIT] = i.initial_addr_word;
		u_taf_mem_model.mem[st + INFO_CNTB] = {16'h0, i.count_b_word};
		u_taf_mem_model.mem[st + INFO_SRC] = i.source_addr_word;
		u_taf_mem_model.mem[st + INFO_DST] = i.dest_addr_word;
		push(1'b0, 1'b0, va, 32'h0);
		push(1'b0, 1'b0, st + INFO_MODE, 32'h0);
		push(1'b0, 1'b0, st + INFO_CNTA, 32'h0);
		if (m[1:0] == MODE_REPEAT) push(1'b0, 1'b1, st + INFO_INIT, 32'h0);
		if (m[1:0] == MODE_BLOCK) push(1'b0, 1'b0, st + INFO_CNTB, 32'h0);
		push(1'b0, 1'b1, st + INFO_SRC, 32'h0);
		push(1'b0, 1'b1, st + INFO_DST, 32'h0);
		exp_info.push_back(i);
		exp_start.push_back(st);
	endtask : job

	task automatic hw(input int s, input logic [15:0] m);
		job(VEC_BASE + 32'(2 * s), {BASE, 16'h0200 + 16'(s * 16)}, m);
	endtask : hw

	task automatic stop_test;
		if (n_mismatch == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : stop_test

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			stop_test();
		end
		if (|src_flag_clear) irq_req <= irq_req & ~src_flag_clear;
		if (wb_ack_o && !wb_we_i) chk(wb_dat_o, exp_rd.pop_front());
		if (resetn && mem_o.req && mem_ack) begin
			if ((mem_o.we ? exp_wr.size() : exp_mem.size()) == 0) chk(80'h1, 80'h0);
			else chk({14'h0, mem_o.we, mem_o.long_acc, mem_o.addr,
				mem_o.wdata & {{16{mem_o.long_acc}}, 16'hffff} & {32{mem_o.we}}},
				mem_o.we ? exp_wr.pop_front() : exp_mem.pop_front());
		end
	end

	// datapath stand-in: takes the info, moves nothing, hands back the update
	initial forever begin
		taf_info_t	i;
		logic [31:0]	st;
		@(posedge sys_clk iff xfer_valid === 1'b1);
		i = exp_info.pop_front();
		st = exp_start.pop_front();
		chk(xfer_info.mode_word, i.mode_word);
		chk(xfer_info.count_a_word, i.count_a_word);
		chk(xfer_info.source_addr_word, i.source_addr_word);
		chk(xfer_info.dest_addr_word, i.dest_addr_word);
		if (i.mode_word[1:0] == MODE_REPEAT) chk(xfer_info.initial_addr_word, i.initial_addr_word);
		if (i.mode_word[1:0] == MODE_BLOCK) chk(xfer_info.count_b_word, i.count_b_word);
		push(1'b1, 1'b0, st + INFO_CNTA, {16'h0, i.count_a_word - 16'h1});
		push(1'b1, 1'b1, st + INFO_SRC, i.source_addr_word + 32'h1);
		push(1'b1, 1'b1, st + INFO_DST, i.dest_addr_word + 32'h1);
		repeat (3) @(posedge sys_clk);
		xfer_update <= {i.count_a_word - 16'h1, i.source_addr_word + 32'h1, i.dest_addr_word + 32'h1, 1'b1};
		xfer_done <= 1'b1;
		@(posedge sys_clk);
		xfer_done <= 1'b0;
	end

	initial begin
		repeat (2) @(posedge sys_clk);
		resetn <= 1'b1;
		rd(OFS_CTRL, {16'h0, CTRL_RESET});
		rd(OFS_ENABLE, {2'h0, ENABLE_RESET});
		rd(8'h10, 32'h0);
		wb(1'b1, OFS_BASE, 4'h3, {16'h0, BASE});
		rd(OFS_BASE, {16'h0, BASE});
		wb(1'b1, OFS_ENABLE, 4'hf, 32'h3fffffff);
		wb(1'b1, OFS_CTRL, 4'h1, 32'h10);
		job(VEC_BASE + 32'h10, {BASE, 16'h0100}, {14'h0, MODE_NORMAL});
		wb(1'b1, OFS_CTRL, 4'h2, 32'h100);
		wb(1'b1, OFS_CTRL, 4'h1, 32'h20);
		settle();
		rd(OFS_CTRL, 32'h10);
		for (int k = 0; k < 3; k++) begin
			int s;
			s = (k * 29 + 1) / 2;
			hw(s, {12'h0, k == 1, 1'b0, 2'(k)});
			irq_req[s] <= 1'b1;
			settle();
			if (k == 1) begin
				rd(OFS_ENABLE, 32'h3fffffff & ~(32'h1 << s));
				chk(cpu_irq[s], 1'b1);
				irq_req <= '0;
				wb(1'b1, OFS_ENABLE, 4'hf, 32'h3fffffff);
			end else chk(irq_req[s], 1'b0);
		end
		hw(3, {14'h0, MODE_NORMAL});
		hw(29, {14'h0, MODE_BLOCK});
		irq_req <= 30'h20000008;
		settle();
		for (int b = 9; b < 11; b++) begin
			if (b == 9) begin
				push(1'b0, 1'b0, VEC_BASE + 32'ha, 32'h0);
				err_addr <= VEC_BASE + 32'ha;
			end else nmi_event <= 1'b1;
			@(posedge sys_clk);
			nmi_event <= 1'b0;
			irq_req[5] <= 1'b1;
			repeat (30) @(posedge sys_clk);
			irq_req <= '0;
			err_addr <= '1;
			rd(OFS_CTRL, 32'h10 | (32'h1 << b));
			wb(1'b1, OFS_CTRL, 4'h2, 32'h1 << b);
			wb(1'b1, OFS_CTRL, 4'h2, 32'h0);
			rd(OFS_CTRL, 32'h10 | (32'h1 << b));
			wb(1'b1, OFS_CTRL, 4'h2, 32'h0);
			rd(OFS_CTRL, 32'h10);
		end
		stop_test();
	end
endmodule : test_transfer_activation_fetch
`default_nettype wire
